// >>> hw/gsn_pkg.sv
// package: register map, field positions, packet constants for the pin and notify block
// Contract
// - mode bit 3 clear drives direction pin low while sending; set drives it high
// - upper four pin-mode bits reserved: written zero, read value ignored
// - direction bit 0 makes a general pin input, 1 makes it output
// - pins given to serial functions are neither driven nor reported by direction
// - masked input pin level change raises one interrupt packet; unmasked change none
// - writing 1 to set register drives the output pin high; 0 no effect
// - writing 1 to clear register drives the output pin low; 0 no effect
// - pin status register returns the present level of each general pin
// - custom bit 0 selects normal data width (0) or wide mode (1)
// - custom bit 1 selects 64 or 63 byte packets; class command sets it
// - low latency set automatically below 46921 bps; software may set it above
// - low latency off: hold receive data until 64 bytes or three-character timeout
// - low latency on: forward all buffered bytes at next bulk in request
// - notify enable bits add pin status to the interrupt data high byte
// - packet header: A1, 20, value 0, index 0, length 0002
// - data low bits: overrun, parity, framing, ring, break, dsr, carrier detect
// - vendor high byte: 14 pin5,13 pin4,12 pin3,11 pin0,9 pin2,8 pin1
// - pin-mode codes 011 and 100 give pin5 to transceiver direction control
package gsn_pkg;
  localparam logic [7:0] ADDR_CUSTOM     = 8'h0C;
  localparam logic [7:0] ADDR_LATENCY    = 8'h10;
  localparam logic [7:0] ADDR_NOTIFY_EN  = 8'h18;
  localparam logic [7:0] ADDR_FUNC_SEL   = 8'h20;
  localparam logic [7:0] ADDR_DIRECTION  = 8'h24;
  localparam logic [7:0] ADDR_CHG_MASK   = 8'h28;
  localparam logic [7:0] ADDR_OUT_SET    = 8'h2C;
  localparam logic [7:0] ADDR_OUT_CLEAR  = 8'h30;
  localparam logic [7:0] ADDR_LEVEL_STAT = 8'h34;
  localparam logic [7:0] ADDR_LINE_STAT  = 8'h38;
  localparam int NPIN           = 6;
  localparam int POLARITY_BIT   = 3;
  localparam int WIDE_BIT       = 0;
  localparam int PKT_LIMIT_BIT  = 1;
  localparam int LATENCY_BIT    = 0;
  localparam logic [2:0] MODE_GPIO     = 3'b000;
  localparam logic [2:0] MODE_RTSCTS   = 3'b001;
  localparam logic [2:0] MODE_DTRDSR   = 3'b010;
  localparam logic [2:0] MODE_RS485    = 3'b011;
  localparam logic [2:0] MODE_RS485_AM = 3'b100;
  localparam logic [7:0] REQ_TYPE      = 8'b10100001;
  localparam logic [7:0] NOTIFY_CODE   = 8'h20;
  localparam logic [15:0] W_VALUE      = 16'h0000;
  localparam logic [15:0] W_INDEX      = 16'h0000;
  localparam logic [15:0] W_LENGTH     = 16'h0002;
  localparam logic [3:0] PKT_BYTES     = 4'hA;
  localparam logic [6:0] FULL_PKT      = 7'h40;
  localparam logic [6:0] SHORT_PKT     = 7'h3F;
  localparam int LOW_LAT_BAUD          = 46921;
  localparam int CLK_HZ                = 25000000;
  localparam int CHAR_BITS             = 10;
  localparam int TIMEOUT_CHARS         = 3;
  localparam logic [7:0] RESET_ZERO    = 8'h00;
endpackage

// >>> hw/gsn_notify_tx.sv
// serialiser: streams one ten-byte notification packet on the interrupt endpoint
`timescale 1ns/100ps
`default_nettype none
module gsn_notify_tx (
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        start_i,
  input  wire logic [15:0] data_i,
  input  wire logic        ready_i,
  output logic             busy_o,
  output logic             valid_o,
  output logic [7:0]       byte_o,
  output logic             last_o
);
  logic [3:0]  idx_reg,   idx_next;
  logic        busy_reg,  busy_next;
  logic [15:0] data_reg,  data_next;

  function automatic logic [7:0] pkt_byte(input logic [3:0] i, input logic [15:0] d);
    case (i)
      4'h0:    pkt_byte = gsn_pkg::REQ_TYPE;
      4'h1:    pkt_byte = gsn_pkg::NOTIFY_CODE;
      4'h2:    pkt_byte = gsn_pkg::W_VALUE[7:0];
      4'h3:    pkt_byte = gsn_pkg::W_VALUE[15:8];
      4'h4:    pkt_byte = gsn_pkg::W_INDEX[7:0];
      4'h5:    pkt_byte = gsn_pkg::W_INDEX[15:8];
      4'h6:    pkt_byte = gsn_pkg::W_LENGTH[7:0];
      4'h7:    pkt_byte = gsn_pkg::W_LENGTH[15:8];
      4'h8:    pkt_byte = d[7:0];
      default: pkt_byte = d[15:8];
    endcase
  endfunction

  always_comb begin
    idx_next  = idx_reg;
    busy_next = busy_reg;
    data_next = data_reg;
    if (!busy_reg && start_i) begin
      busy_next = 1'b1;
      idx_next  = 4'h0;
      data_next = data_i;
    end else if (busy_reg && ready_i) begin
      if (idx_reg == gsn_pkg::PKT_BYTES - 4'h1) begin
        busy_next = 1'b0;
      end else begin
        idx_next = idx_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      idx_reg  <= 4'h0;
      busy_reg <= 1'b0;
      data_reg <= 16'h0000;
    end else begin
      idx_reg  <= idx_next;
      busy_reg <= busy_next;
      data_reg <= data_next;
    end
  end

  assign busy_o  = busy_reg;
  assign valid_o = busy_reg;
  assign byte_o  = pkt_byte(idx_reg, data_reg);
  assign last_o  = busy_reg && (idx_reg == gsn_pkg::PKT_BYTES - 4'h1);
endmodule
`default_nettype wire

// >>> hw/gsn_top.sv
// top: ahb-lite registers, general pins, change notify and receive forwarding gate
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module gsn_top #(
  parameter int unsigned TIMEOUT_CYCLES = 40000
) (
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic [5:0]  aux_pin_n_i,
  output logic [5:0]       aux_pin_n_o,
  output logic [5:0]       aux_pin_n_oe_o,
  input  wire logic        uart_tx_active_i,
  input  wire logic        addr_match_i,
  input  wire logic        serial_rts_i,
  input  wire logic        serial_dtr_i,
  input  wire logic [6:0]  line_state_i,
  input  wire logic        line_error_evt_i,
  input  wire logic        class_cmd_evt_i,
  input  wire logic        slow_baud_i,
  input  wire logic        baud_change_i,
  input  wire logic [8:0]  rx_fifo_count_i,
  input  wire logic        rx_byte_evt_i,
  input  wire logic        bulk_in_req_i,
  output logic             rx_forward_o,
  output logic [6:0]       packet_limit_select_o,
  output logic             wide_mode_o,
  input  wire logic        intr_ready_i,
  output logic             intr_valid_o,
  output logic [7:0]       intr_byte_o,
  output logic             intr_last_o
);
  // bus state
  logic        wr_pend_reg, wr_pend_next;
  logic [7:0]  wr_addr_reg, wr_addr_next;
  logic [31:0] rdata_reg,   rdata_next;
  // control registers
  logic [7:0]  func_sel_reg, func_sel_next;
  logic [5:0]  dir_reg,      dir_next;
  logic [5:0]  mask_reg,     mask_next;
  logic [5:0]  out_reg,      out_next;
  logic [1:0]  custom_reg,   custom_next;
  logic        lat_reg,      lat_next;
  logic [7:0]  notify_en_reg, notify_en_next;
  // pin sampling
  logic [5:0]  pin_s1_reg, pin_s2_reg, pin_prev_reg;
  // outputs
  logic [5:0]  pin_o_reg, pin_o_next;
  logic [5:0]  pin_oe_reg, pin_oe_next;
  logic        fwd_reg, fwd_next;
  // notify queue and timeout
  logic [3:0]  pend_cnt_reg, pend_cnt_next;
  logic [31:0] idle_cnt_reg, idle_cnt_next;
  logic        tx_busy, tx_valid, tx_last;
  logic [7:0]  tx_byte;
  logic        tx_start;
  logic [15:0] notify_data;

  logic        addr_ok;
  logic [5:0]  gpio_own;
  logic [5:0]  chg_evt;
  logic        evt;

  // which pins remain general-purpose under the current function select
  function automatic logic [5:0] gpio_pins(input logic [2:0] m);
    case (m)
      gsn_pkg::MODE_RTSCTS:   gpio_pins = 6'h0F;
      gsn_pkg::MODE_DTRDSR:   gpio_pins = 6'h33;
      gsn_pkg::MODE_RS485,
      gsn_pkg::MODE_RS485_AM: gpio_pins = 6'h1F;
      default:                gpio_pins = 6'h3F;
    endcase
  endfunction

  assign gpio_own = gpio_pins(func_sel_reg[2:0]);
  assign addr_ok  = hsel_i && htrans_i[1] && hready_i;
  assign chg_evt  = (pin_s2_reg ^ pin_prev_reg) & mask_reg & ~dir_reg & gpio_own;
  assign evt      = (|chg_evt) || line_error_evt_i;

  // vendor data field: line state low, enabled pin levels high
  always_comb begin
    notify_data       = 16'h0000;
    notify_data[6:0]  = line_state_i;
    notify_data[8]    = pin_s2_reg[1] & notify_en_reg[0];
    notify_data[9]    = pin_s2_reg[2] & notify_en_reg[1];
    notify_data[11]   = pin_s2_reg[0] & notify_en_reg[3];
    notify_data[12]   = pin_s2_reg[3] & notify_en_reg[4];
    notify_data[13]   = pin_s2_reg[4] & notify_en_reg[5];
    notify_data[14]   = pin_s2_reg[5] & notify_en_reg[6];
  end

  always_comb begin
    wr_pend_next   = 1'b0;
    wr_addr_next   = wr_addr_reg;
    rdata_next     = rdata_reg;
    func_sel_next  = func_sel_reg;
    dir_next       = dir_reg;
    mask_next      = mask_reg;
    out_next       = out_reg;
    custom_next    = custom_reg;
    lat_next       = lat_reg;
    notify_en_next = notify_en_reg;
    if (addr_ok && hwrite_i) begin
      wr_pend_next = 1'b1;
      wr_addr_next = haddr_i[7:0];
    end
    if (wr_pend_reg) begin
      case (wr_addr_reg)
        gsn_pkg::ADDR_CUSTOM:    custom_next = hwdata_i[1:0];
        gsn_pkg::ADDR_LATENCY:   lat_next = hwdata_i[gsn_pkg::LATENCY_BIT];
        gsn_pkg::ADDR_NOTIFY_EN: notify_en_next = hwdata_i[7:0] & 8'h7B;
        gsn_pkg::ADDR_FUNC_SEL:  func_sel_next = {4'h0, hwdata_i[3:0]};
        gsn_pkg::ADDR_DIRECTION: dir_next = hwdata_i[5:0];
        gsn_pkg::ADDR_CHG_MASK:  mask_next = hwdata_i[5:0];
        gsn_pkg::ADDR_OUT_SET:   out_next = out_reg | hwdata_i[5:0];
        gsn_pkg::ADDR_OUT_CLEAR: out_next = out_reg & ~hwdata_i[5:0];
        default:                 out_next = out_reg;
      endcase
    end
    // hardware sets take precedence over a concurrent software write
    if (class_cmd_evt_i) begin
      custom_next[gsn_pkg::PKT_LIMIT_BIT] = 1'b1;
    end
    if (baud_change_i && slow_baud_i) begin
      lat_next = 1'b1;
    end
    // read from the next values: a read right behind a write must see the written word
    if (addr_ok && !hwrite_i) begin
      case (haddr_i[7:0])
        gsn_pkg::ADDR_CUSTOM:     rdata_next = {30'h0, custom_next};
        gsn_pkg::ADDR_LATENCY:    rdata_next = {31'h0, lat_next};
        gsn_pkg::ADDR_NOTIFY_EN:  rdata_next = {24'h0, notify_en_next};
        gsn_pkg::ADDR_FUNC_SEL:   rdata_next = {28'h0, func_sel_next[3:0]};
        gsn_pkg::ADDR_DIRECTION:  rdata_next = {26'h0, dir_next & gpio_pins(func_sel_next[2:0])};
        gsn_pkg::ADDR_CHG_MASK:   rdata_next = {26'h0, mask_next};
        gsn_pkg::ADDR_LEVEL_STAT: rdata_next = {26'h0, pin_s2_reg};
        gsn_pkg::ADDR_LINE_STAT:  rdata_next = {25'h0, line_state_i};
        default:                  rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // pin drive: general output pins, plus pin5 RTS in mode 001, pin3 DTR in mode 010, pin5 transceiver direction in 485 modes
  always_comb begin
    pin_o_next  = out_reg;
    pin_oe_next = dir_reg & gpio_own;
    case (func_sel_reg[2:0])
      gsn_pkg::MODE_RTSCTS: begin
        pin_o_next[5]  = serial_rts_i;
        pin_oe_next[5] = 1'b1;
      end
      gsn_pkg::MODE_DTRDSR: begin
        pin_o_next[3]  = serial_dtr_i;
        pin_oe_next[3] = 1'b1;
      end
      gsn_pkg::MODE_RS485, gsn_pkg::MODE_RS485_AM: begin
        // mode 100 only keys the transceiver once the address has matched
        pin_o_next[5]  = (uart_tx_active_i && (func_sel_reg[2:0] == gsn_pkg::MODE_RS485
                          || addr_match_i)) ~^ func_sel_reg[gsn_pkg::POLARITY_BIT];
        pin_oe_next[5] = 1'b1;
      end
      default: begin
        pin_o_next  = out_reg;
      end
    endcase
  end

  // receive forwarding gate; timeout counts idle time since the last received byte
  always_comb begin
    idle_cnt_next = idle_cnt_reg;
    if (rx_byte_evt_i || rx_fifo_count_i == 9'h000) begin
      idle_cnt_next = 32'h0;
    end else if (idle_cnt_reg < TIMEOUT_CYCLES) begin
      idle_cnt_next = idle_cnt_reg + 32'h1;
    end
    if (lat_reg) begin
      fwd_next = bulk_in_req_i && (rx_fifo_count_i != 9'h000);
    end else begin
      fwd_next = bulk_in_req_i && (rx_fifo_count_i >= 9'(gsn_pkg::FULL_PKT)
                 || (rx_fifo_count_i != 9'h000 && idle_cnt_reg >= TIMEOUT_CYCLES));
    end
  end

  // pending packet counter: an event in the start cycle is still counted
  assign tx_start = !tx_busy && (pend_cnt_reg != 4'h0);
  always_comb begin
    pend_cnt_next = pend_cnt_reg;
    if (evt && !tx_start && pend_cnt_reg != 4'hF) begin
      pend_cnt_next = pend_cnt_reg + 4'h1;
    end else if (!evt && tx_start) begin
      pend_cnt_next = pend_cnt_reg - 4'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wr_pend_reg   <= 1'b0;
      wr_addr_reg   <= 8'h00;
      rdata_reg     <= 32'h0000_0000;
      func_sel_reg  <= gsn_pkg::RESET_ZERO;
      dir_reg       <= 6'h00;
      mask_reg      <= 6'h00;
      out_reg       <= 6'h00;
      custom_reg    <= 2'h0;
      lat_reg       <= 1'b0;
      notify_en_reg <= gsn_pkg::RESET_ZERO;
      pin_s1_reg    <= 6'h00;
      pin_s2_reg    <= 6'h00;
      pin_prev_reg  <= 6'h00;
      pin_o_reg     <= 6'h00;
      pin_oe_reg    <= 6'h00;
      fwd_reg       <= 1'b0;
      pend_cnt_reg  <= 4'h0;
      idle_cnt_reg  <= 32'h0;
    end else begin
      wr_pend_reg   <= wr_pend_next;
      wr_addr_reg   <= wr_addr_next;
      rdata_reg     <= rdata_next;
      func_sel_reg  <= func_sel_next;
      dir_reg       <= dir_next;
      mask_reg      <= mask_next;
      out_reg       <= out_next;
      custom_reg    <= custom_next;
      lat_reg       <= lat_next;
      notify_en_reg <= notify_en_next;
      pin_s1_reg    <= aux_pin_n_i;
      pin_s2_reg    <= pin_s1_reg;
      pin_prev_reg  <= pin_s2_reg;
      pin_o_reg     <= pin_o_next;
      pin_oe_reg    <= pin_oe_next;
      fwd_reg       <= fwd_next;
      pend_cnt_reg  <= pend_cnt_next;
      idle_cnt_reg  <= idle_cnt_next;
    end
  end

  gsn_notify_tx u_notify (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (tx_start),
    .data_i    (notify_data),
    .ready_i   (intr_ready_i),
    .busy_o    (tx_busy),
    .valid_o   (tx_valid),
    .byte_o    (tx_byte),
    .last_o    (tx_last)
  );

  // outputs from flip-flops, except constant hreadyout_o and hresp_o; notify stream comes from the serialiser registers
  assign hrdata_o              = rdata_reg;
  assign hreadyout_o           = 1'b1;
  assign hresp_o               = 1'b0;
  assign aux_pin_n_o           = pin_o_reg;
  assign aux_pin_n_oe_o        = pin_oe_reg;
  assign rx_forward_o          = fwd_reg;
  assign wide_mode_o           = custom_reg[gsn_pkg::WIDE_BIT];
  assign packet_limit_select_o = custom_reg[gsn_pkg::PKT_LIMIT_BIT] ? gsn_pkg::SHORT_PKT
                                                                   : gsn_pkg::FULL_PKT;
  assign intr_valid_o          = tx_valid;
  assign intr_byte_o           = tx_byte;
  assign intr_last_o           = tx_last;
endmodule
`default_nettype wire

// >>> testbench/gsn_top_checker.sv
// checker: interrupt stream framing, forward gate and packet limit relations
`timescale 1ns/100ps
`default_nettype none
module gsn_top_checker #(
  parameter int unsigned TIMEOUT_CYCLES = 40000
) (
  input wire logic       clock_i,
  input wire logic       sys_rst_i,
  input wire logic       intr_ready_i,
  input wire logic       intr_valid_o,
  input wire logic [7:0] intr_byte_o,
  input wire logic       intr_last_o,
  input wire logic       bulk_in_req_i,
  input wire logic       rx_forward_o,
  input wire logic [6:0] packet_limit_select_o,
  input wire logic       class_cmd_evt_i
);
  logic [3:0] idx_reg;
  logic [3:0] idx_next;
  // byte position inside the packet, counted from accepted bytes only
  always_comb begin
    idx_next = idx_reg;
    if (intr_valid_o && intr_ready_i) idx_next = intr_last_o ? 4'h0 : idx_reg + 4'h1;
  end
  always_ff @(posedge clock_i) begin
    idx_reg <= sys_rst_i ? 4'h0 : idx_next;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_waiting; intr_valid_o && !intr_ready_i; endsequence
  sequence s_held; intr_valid_o && $stable(intr_byte_o) && $stable(intr_last_o); endsequence
  property p_head; intr_valid_o && idx_reg == 4'h0 |-> intr_byte_o == gsn_pkg::REQ_TYPE; endproperty
  a_head: assert property (p_head) else $error("first byte is not the request type");
  property p_code; intr_valid_o && idx_reg == 4'h1 |-> intr_byte_o == gsn_pkg::NOTIFY_CODE; endproperty
  a_code: assert property (p_code) else $error("second byte is not the notify code");
  property p_len; intr_valid_o && idx_reg == 4'h6 |-> intr_byte_o == 8'h02; endproperty
  a_len: assert property (p_len) else $error("length byte wrong");
  property p_last; intr_valid_o |-> (intr_last_o == (idx_reg == 4'h9)); endproperty
  a_last: assert property (p_last) else $error("last flag not on tenth byte");
  property p_hold; s_waiting |=> s_held; endproperty
  a_hold: assert property (p_hold) else $error("byte dropped before acceptance");
  property p_lo_rsv; intr_valid_o && idx_reg == 4'h8 |-> !intr_byte_o[7]; endproperty
  a_lo_rsv: assert property (p_lo_rsv) else $error("data bit 7 set");
  property p_hi_rsv; intr_valid_o && intr_last_o |-> !intr_byte_o[7] && !intr_byte_o[2]; endproperty
  a_hi_rsv: assert property (p_hi_rsv) else $error("data bit 15 or 10 set");
  property p_fwd; $rose(rx_forward_o) |-> $past(bulk_in_req_i); endproperty
  a_fwd: assert property (p_fwd) else $error("forward without bulk request");
  property p_lim; packet_limit_select_o == 7'h40 || packet_limit_select_o == 7'h3F; endproperty
  a_lim: assert property (p_lim) else $error("packet limit neither 64 nor 63");
  property p_cls; class_cmd_evt_i |-> ##[1:3] packet_limit_select_o == 7'h3F; endproperty
  a_cls: assert property (p_cls) else $error("class command did not select 63");
endmodule
bind gsn_top gsn_top_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .intr_ready_i(intr_ready_i),
  .intr_valid_o(intr_valid_o), .intr_byte_o(intr_byte_o), .intr_last_o(intr_last_o),
  .bulk_in_req_i(bulk_in_req_i), .rx_forward_o(rx_forward_o),
  .packet_limit_select_o(packet_limit_select_o), .class_cmd_evt_i(class_cmd_evt_i));
`default_nettype wire

// >>> testbench/gsn_host_model.sv
// host model: polls the interrupt endpoint, promptly or with every other cycle stalled
`timescale 1ns/100ps
`default_nettype none
module gsn_host_model (
  input wire logic       clock_i,
  input wire logic       sys_rst_i,
  input wire logic       slow_i,
  input wire logic       intr_valid_i,
  input wire logic [7:0] intr_byte_i,
  input wire logic       intr_last_i,
  output logic           intr_ready_o
);
  logic [7:0] got[$];
  int         npkt = 0;
  always @(posedge clock_i) begin
    if (intr_valid_i && intr_ready_o) begin
      got.push_back(intr_byte_i);
      if (intr_last_i) npkt <= npkt + 1;
    end
    intr_ready_o <= sys_rst_i ? 1'b0 : (slow_i ? ~intr_ready_o : 1'b1);
  end
endmodule
`default_nettype wire

// >>> testbench/gsn_top_bench.sv
// bench: register access, pins, notify packets and receive forwarding
`timescale 1ns/100ps
`default_nettype none
module gsn_top_bench;
  logic clock_i, sys_rst_i, hsel, hwrite, hrdy, hresp, utx, amatch, rts, dtr, lerr, ccmd;
  logic slowb, bchg, rxevt, bulk, fwd, wide, irdy, ivld, ilast, slowh;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [5:0]  ext, pin_o, pin_oe, pin_i, dmask[5], omask[5];
  logic [6:0]  lstate, plim;
  logic [8:0]  fcnt;
  logic [7:0]  ibyte;
  int          n_mismatch = 0, compares = 0, cyc = 0, base;
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext);
  gsn_top #(.TIMEOUT_CYCLES(20)) uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
    .aux_pin_n_i(pin_i), .aux_pin_n_o(pin_o), .aux_pin_n_oe_o(pin_oe), .uart_tx_active_i(utx),
    .addr_match_i(amatch), .serial_rts_i(rts), .serial_dtr_i(dtr), .line_state_i(lstate),
    .line_error_evt_i(lerr), .class_cmd_evt_i(ccmd), .slow_baud_i(slowb), .baud_change_i(bchg),
    .rx_fifo_count_i(fcnt), .rx_byte_evt_i(rxevt), .bulk_in_req_i(bulk), .rx_forward_o(fwd),
    .packet_limit_select_o(plim), .wide_mode_o(wide), .intr_ready_i(irdy),
    .intr_valid_o(ivld), .intr_byte_o(ibyte), .intr_last_o(ilast));
  gsn_host_model host (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .slow_i(slowh),
    .intr_valid_i(ivld), .intr_byte_i(ibyte), .intr_last_i(ilast), .intr_ready_o(irdy));
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  task automatic tally_and_finish();
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // single word transfer; read data is taken at the edge that ends the data phase
  task automatic ahb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1; haddr <= {24'h000000, a}; htrans <= 2'b10; hwrite <= wr_en; hsize <= 3'b010;
    do @(posedge clock_i); while (hrdy !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    do @(posedge clock_i); while (hrdy !== 1'b1);
    rd = hrdata;
    check("response", 32'(hresp), 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    ahb(1'b0, a, 32'h00000000);
    check(what, rd, exp);
  endtask
  // one-cycle strobe: 0 line error, 1 class command, 2 baud change, 3 received byte
  task automatic pulse(input int k);
    case (k)
      0: lerr <= 1'b1;
      1: ccmd <= 1'b1;
      2: bchg <= 1'b1;
      default: rxevt <= 1'b1;
    endcase
    @(posedge clock_i);
    {lerr, ccmd, bchg, rxevt} <= 4'h0;
    @(posedge clock_i);
  endtask
  task automatic wait_pkts(input int n);
    for (int k = 0; k < 400 && host.npkt < n; k++) @(posedge clock_i);
    check("packet count", 32'(host.npkt), 32'(n));
  endtask
  task automatic exp_pkt(input int n, input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] e[10];
    e = '{8'hA1, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, lo, hi};
    for (int i = 0; i < 10; i++) check("packet byte", 32'(host.got[n * 10 + i]), 32'(e[i]));
  endtask
  // bulk request, after a fresh received byte when evt is set; forward flag looked at once it has settled
  task automatic fwd_case(input logic [8:0] cnt, input logic exp, input logic evt);
    fcnt <= cnt;
    if (evt) pulse(3);
    bulk <= 1'b1;
    @(posedge clock_i);
    @(posedge clock_i);
    #1 check("rx forward", 32'(fwd), 32'(exp));
    @(posedge clock_i);
    bulk <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask
  initial begin
    {hsel, hwrite, utx, amatch, rts, dtr, lerr, ccmd, slowb, bchg, rxevt, bulk, slowh} = '0;
    haddr = '0; hwdata = '0; htrans = 2'b00; hsize = 3'b010; ext = 6'h2B;
    lstate = 7'h00; fcnt = 9'h000; sys_rst_i = 1'b1;
    dmask = '{6'h3F, 6'h0F, 6'h33, 6'h1F, 6'h1F};
    omask = '{6'h3F, 6'h2F, 6'h3B, 6'h3F, 6'h3F};
    repeat (16) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    check("packet limit", 32'(plim), 32'h40);
    check("pin enables", 32'(pin_oe), 32'h0);
    rdchk(gsn_pkg::ADDR_CUSTOM, 32'h0, "custom reset");
    wr(8'h3C, 32'hFF);
    rdchk(8'h3C, 32'h0, "unmapped");
    for (int m = 0; m < 5; m++) begin
      wr(gsn_pkg::ADDR_FUNC_SEL, 32'(m));
      wr(gsn_pkg::ADDR_DIRECTION, 32'h3F);
      rdchk(gsn_pkg::ADDR_DIRECTION, 32'(dmask[m]), "direction view");
      ahb(1'b0, gsn_pkg::ADDR_FUNC_SEL, 32'h0);
      check("mode", 32'(rd[3:0]), 32'(m));
      check("pin enables", 32'(pin_oe), 32'(omask[m]));
    end
    wr(gsn_pkg::ADDR_FUNC_SEL, 32'h0);
    wr(gsn_pkg::ADDR_DIRECTION, 32'h0F);
    wr(gsn_pkg::ADDR_OUT_SET, 32'h05);
    wr(gsn_pkg::ADDR_OUT_SET, 32'h02);
    repeat (2) @(posedge clock_i);
    check("pin enables", 32'(pin_oe), 32'h0F);
    check("set drive", 32'(pin_o & 6'h0F), 32'h07);
    wr(gsn_pkg::ADDR_OUT_CLEAR, 32'h04);
    repeat (2) @(posedge clock_i);
    check("clear drive", 32'(pin_o & 6'h0F), 32'h03);
    repeat (4) @(posedge clock_i);
    rdchk(gsn_pkg::ADDR_LEVEL_STAT, 32'h23, "pin levels");
    amatch <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      wr(gsn_pkg::ADDR_FUNC_SEL, 32'(3 + p % 2 + 8 * (p / 2)));
      utx <= 1'b1;
      repeat (3) @(posedge clock_i);
      check("dir pin active", 32'(pin_o[5]), 32'(p / 2));
      check("dir pin driven", 32'(pin_oe[5]), 32'h1);
      utx <= 1'b0;
      repeat (3) @(posedge clock_i);
      check("dir pin idle", 32'(pin_o[5]), 32'(1 - p / 2));
    end
    amatch <= 1'b0;
    wr(gsn_pkg::ADDR_FUNC_SEL, 32'h4);
    utx <= 1'b1;
    repeat (3) @(posedge clock_i);
    check("dir pin no match", 32'(pin_o[5]), 32'h1);
    utx <= 1'b0;
    wr(gsn_pkg::ADDR_FUNC_SEL, 32'h0);
    wr(gsn_pkg::ADDR_DIRECTION, 32'h0);
    wr(gsn_pkg::ADDR_NOTIFY_EN, 32'h7B);
    wr(gsn_pkg::ADDR_CHG_MASK, 32'h01);
    rdchk(gsn_pkg::ADDR_NOTIFY_EN, 32'h7B, "notify enable");
    rdchk(gsn_pkg::ADDR_CHG_MASK, 32'h01, "change mask");
    lstate <= 7'h55;
    repeat (8) @(posedge clock_i);
    rdchk(gsn_pkg::ADDR_LINE_STAT, 32'h55, "line state");
    base = host.npkt;
    ext <= 6'h2A;
    wait_pkts(base + 1);
    exp_pkt(base, 8'h55, 8'h51);
    ext <= 6'h28;
    repeat (40) @(posedge clock_i);
    check("unmasked change", 32'(host.npkt), 32'(base + 1));
    slowh <= 1'b1;
    pulse(0);
    wait_pkts(base + 2);
    exp_pkt(base + 1, 8'h55, 8'h50);
    wr(gsn_pkg::ADDR_NOTIFY_EN, 32'h0);
    pulse(0);
    pulse(0);
    wait_pkts(base + 4);
    exp_pkt(base + 3, 8'h55, 8'h00);
    slowh <= 1'b0;
    wr(gsn_pkg::ADDR_CUSTOM, 32'h03);
    repeat (2) @(posedge clock_i);
    check("wide", 32'(wide), 32'h1);
    check("packet limit", 32'(plim), 32'h3F);
    wr(gsn_pkg::ADDR_CUSTOM, 32'h0);
    repeat (2) @(posedge clock_i);
    check("wide", 32'(wide), 32'h0);
    pulse(1);
    repeat (2) @(posedge clock_i);
    rdchk(gsn_pkg::ADDR_CUSTOM, 32'h02, "custom after class");
    wr(gsn_pkg::ADDR_LATENCY, 32'h0);
    slowb <= 1'b1;
    pulse(2);
    rdchk(gsn_pkg::ADDR_LATENCY, 32'h1, "auto latency");
    slowb <= 1'b0;
    wr(gsn_pkg::ADDR_LATENCY, 32'h0);
    fwd_case(9'd5, 1'b0, 1'b1);
    fwd_case(9'd64, 1'b1, 1'b1);
    repeat (40) @(posedge clock_i);
    fwd_case(9'd5, 1'b1, 1'b0);
    wr(gsn_pkg::ADDR_LATENCY, 32'h1);
    fwd_case(9'd1, 1'b1, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
